// File: verilog/ifa_pkg.sv
package ifa_pkg;
    localparam int NCH = 4;
    localparam int NAL = 6;
    localparam int PV_W = 16;
    localparam int AV_W = 18;
    // Alarm slots within a channel
    localparam int AL_HH = 0;
    localparam int AL_H = 1;
    localparam int AL_LL = 2;
    localparam int AL_L = 3;
    localparam int AL_RH = 4;
    localparam int AL_RL = 5;
    // Process value scale: 0 is range bottom, 10000 is range top
    localparam logic signed [15:0] PV_SPAN = 16'sh2710;
    localparam logic signed [15:0] PV_HI_115 = 16'sh2CEC;
    localparam logic signed [15:0] PV_LO_15 = -16'sh05DC;
    localparam logic signed [15:0] PV_HI_1075 = 16'sh29FE;
    localparam logic signed [15:0] PV_LO_75 = -16'sh02EE;
    localparam logic signed [15:0] PV_ZERO = 16'sh0000;
    localparam logic signed [15:0] PV_MID = 16'sh1388;
    // Timing
    localparam int CLK_HZ = 50_000_000;
    localparam int MS_PER_S = 1000;
    localparam int MS_CYC_DEF = CLK_HZ / MS_PER_S;
    localparam logic [5:0] CONV_HIGH_MS = 6'h3C;
    localparam logic [5:0] CONV_MED_MS = 6'h0A;
    localparam logic [5:0] CONV_LOW_MS = 6'h05;
    localparam logic [1:0] RES_HIGH = 2'h0;
    localparam logic [1:0] RES_MED = 2'h1;
    localparam logic [12:0] BRK_PT4_MS = 13'h1388;
    localparam logic [12:0] BRK_MV_MS = 13'h03E8;
    localparam logic [12:0] BRK_TEMP_MS = 13'h01F4;
    localparam logic [12:0] BRK_MARGIN_MS = 13'h0064;
    localparam logic [5:0] DLY_MAX_S = 6'h3C;
    localparam logic [15:0] DLY_MS_PER_S = 16'h03E8;
    localparam logic [4:0] RATE_MAX_S = 5'h10;
    localparam logic [9:0] SEC_LAST_MS = 10'h3E7;

    typedef enum logic [2:0] {
        RNG_PT4,
        RNG_TEMP,
        RNG_MV100,
        RNG_LIVE0,
        RNG_UNI,
        RNG_MA020,
        RNG_BIPOLAR
    } ifa_range_t;
endpackage

// File: verilog/ifa_check.sv
// Functional notes
// - Temperature/mV/pot: fault on break or out-of-band.
// - Temperature/mV break clamps high 115% or low -15%.
// - Break detected within 5s, 1s, 0.5s.
// - 4-20mA/1-5V break stores -15% value.
// - Other unipolar voltage break stores 0 V value.
// - 0-20mA faults only above 115%.
// - 0-20mA break stores 0 mA value.
// - Bipolar faults above 107.5% or below -7.5%.
// - Bipolar break stores 0 V value.
// - Four level alarms, hysteresis, 0-60s delay.
// - Rate over 1-16s or one conversion period.
// - Two rate alarms, hysteresis, shared delay.
// - Conversion period 60, 10 or 5 ms.
`timescale 1ns/1ps
`default_nettype none
module ifa_check #(
    parameter int unsigned MS_CYC = ifa_pkg::MS_CYC_DEF
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic [1:0] resSel,
    input wire ifa_pkg::ifa_range_t [3:0] rangeSel,
    input wire logic [3:0] clampHigh,
    input wire logic [3:0] wireBreak,
    input wire logic [3:0][15:0] sampleValue,
    input wire logic [3:0][5:0][15:0] alarmLimit,
    input wire logic [3:0][5:0][15:0] alarmHyst,
    input wire logic [3:0][5:0] alarmDelaySec,
    input wire logic [3:0][4:0] rateIntervalSec,
    output logic convTick,
    output wire logic [3:0][15:0] processValue,
    output wire logic [3:0] input_fault_flag,
    output wire logic [3:0] breakDetected,
    output wire logic [3:0][16:0] rateValue,
    output wire logic [3:0][5:0] alarmFlags
);
    import ifa_pkg::*;

    logic [15:0] msCnt;
    logic msTick;
    logic [5:0] convMs;
    logic [5:0] periodMs;
    logic [9:0] secMs;
    logic secTick;
    logic evalTick;
    logic alarmTick;

    // Millisecond time base; all delays are counted in these ticks
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            msCnt <= 16'h0000;
            msTick <= 1'b0;
        end else if (clkEn) begin
            if (msCnt == 16'(MS_CYC - 1)) begin
                msCnt <= 16'h0000;
                msTick <= 1'b1;
            end else begin
                msCnt <= msCnt + 16'h0001;
                msTick <= 1'b0;
            end
        end
    end

    always_comb begin
        case (resSel)
            RES_HIGH: periodMs = CONV_HIGH_MS;
            RES_MED: periodMs = CONV_MED_MS;
            default: periodMs = CONV_LOW_MS;
        endcase
    end

    // Conversion period: one pass over all four channels
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            convMs <= 6'h00;
            convTick <= 1'b0;
        end else if (clkEn) begin
            convTick <= 1'b0;
            if (msTick) begin
                if (convMs >= periodMs - 6'h01) begin
                    convMs <= 6'h00;
                    convTick <= 1'b1;
                end else begin
                    convMs <= convMs + 6'h01;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            secMs <= 10'h000;
            secTick <= 1'b0;
        end else if (clkEn) begin
            secTick <= 1'b0;
            if (msTick) begin
                if (secMs == SEC_LAST_MS) begin
                    secMs <= 10'h000;
                    secTick <= 1'b1;
                end else begin
                    secMs <= secMs + 10'h001;
                end
            end
        end
    end

    // Values settle, then rate, then alarms: one stage per cycle
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            evalTick <= 1'b0;
            alarmTick <= 1'b0;
        end else if (clkEn) begin
            evalTick <= convTick;
            alarmTick <= evalTick;
        end
    end

    for (genvar ch = 0; ch < NCH; ch++) begin : gCh
        logic brkS1;
        logic brkS2;
        logic brkS3;
        logic brkLevel;
        logic [12:0] brkMs;
        logic [12:0] qualMs;
        logic brkQual;
        logic signed [15:0] raw;
        logic signed [15:0] hiLim;
        logic signed [15:0] loLim;
        logic loChk;
        logic brkFault;
        logic signed [15:0] clampVal;
        logic outBand;
        logic signed [15:0] pv;
        logic fault;
        logic brkOut;
        logic signed [15:0] refVal;
        logic primed;
        logic [4:0] secElapsed;
        logic [4:0] interval;
        logic signed [16:0] rate;
        logic [5:0] dlySec;
        logic [15:0] delayMs;

        // Break input is asynchronous: count a change once stages agree
        always_ff @(posedge core_clk or negedge reset_n) begin
            if (!reset_n) begin
                brkS1 <= 1'b0;
                brkS2 <= 1'b0;
                brkS3 <= 1'b0;
                brkLevel <= 1'b0;
            end else if (clkEn) begin
                brkS1 <= wireBreak[ch];
                brkS2 <= brkS1;
                brkS3 <= brkS2;
                if (brkS2 == brkS3) begin
                    brkLevel <= brkS3;
                end
            end
        end

        // Qualify a little short of the limit to absorb period jitter
        always_comb begin
            case (rangeSel[ch])
                RNG_PT4: qualMs = BRK_PT4_MS - BRK_MARGIN_MS;
                RNG_MV100: qualMs = BRK_MV_MS - BRK_MARGIN_MS;
                default: qualMs = BRK_TEMP_MS - BRK_MARGIN_MS;
            endcase
        end

        always_ff @(posedge core_clk or negedge reset_n) begin
            if (!reset_n) begin
                brkMs <= 13'h0000;
            end else if (clkEn) begin
                if (!brkLevel) begin
                    brkMs <= 13'h0000;
                end else if (msTick && brkMs < qualMs) begin
                    brkMs <= brkMs + 13'h0001;
                end
            end
        end

        assign brkQual = brkMs >= qualMs;
        assign raw = $signed(sampleValue[ch]);

        always_comb begin
            hiLim = PV_HI_115;
            loLim = PV_LO_15;
            loChk = 1'b1;
            brkFault = 1'b1;
            clampVal = clampHigh[ch] ? PV_HI_115 : PV_LO_15;
            case (rangeSel[ch])
                RNG_PT4, RNG_TEMP, RNG_MV100: begin
                end
                RNG_LIVE0: clampVal = PV_LO_15;
                RNG_UNI: clampVal = PV_ZERO;
                RNG_MA020: begin
                    loChk = 1'b0;
                    brkFault = 1'b0;
                    clampVal = PV_ZERO;
                end
                RNG_BIPOLAR: begin
                    hiLim = PV_HI_1075;
                    loLim = PV_LO_75;
                    brkFault = 1'b0;
                    clampVal = PV_MID;
                end
                default: begin
                end
            endcase
            outBand = (raw > hiLim) || (loChk && raw < loLim);
        end

        always_ff @(posedge core_clk or negedge reset_n) begin
            if (!reset_n) begin
                pv <= PV_ZERO;
                fault <= 1'b0;
                brkOut <= 1'b0;
            end else if (clkEn && convTick) begin
                pv <= brkQual ? clampVal : raw;
                fault <= brkQual ? brkFault : outBand;
                brkOut <= brkQual;
            end
        end

        assign interval = (rateIntervalSec[ch] > RATE_MAX_S) ? RATE_MAX_S : rateIntervalSec[ch];

        // First pass only seeds the reference so no bogus step is reported
        always_ff @(posedge core_clk or negedge reset_n) begin
            if (!reset_n) begin
                refVal <= PV_ZERO;
                primed <= 1'b0;
                secElapsed <= 5'h00;
                rate <= 17'h0_0000;
            end else if (clkEn) begin
                if (evalTick && (!primed || interval == 5'h00 || secElapsed >= interval)) begin
                    refVal <= pv;
                    primed <= 1'b1;
                    secElapsed <= 5'h00;
                    if (primed) begin
                        rate <= 17'(pv) - 17'(refVal);
                    end
                end else if (secTick && secElapsed < RATE_MAX_S) begin
                    secElapsed <= secElapsed + 5'h01;
                end
            end
        end

        assign dlySec = (alarmDelaySec[ch] > DLY_MAX_S) ? DLY_MAX_S : alarmDelaySec[ch];
        assign delayMs = 16'({10'h000, dlySec} * DLY_MS_PER_S);

        for (genvar a = 0; a < NAL; a++) begin : gAl
            localparam bit HIGH_TYPE = (a == AL_HH) || (a == AL_H) || (a == AL_RH);
            logic signed [17:0] val;
            logic signed [17:0] lim;
            logic signed [17:0] hy;
            logic setCond;
            logic clrCond;
            logic want;
            logic pending;
            logic [15:0] dlyMs;
            logic alarm;

            assign val = (a < AL_RH) ? AV_W'(pv) : AV_W'(rate);
            assign lim = AV_W'($signed(alarmLimit[ch][a]));
            assign hy = {2'b00, alarmHyst[ch][a]};
            assign setCond = HIGH_TYPE ? (val > lim) : (val < lim);
            assign clrCond = HIGH_TYPE ? (val <= lim - hy) : (val >= lim + hy);
            assign want = alarm ? clrCond : setCond;

            // Condition is sampled once per period; timer runs between samples
            always_ff @(posedge core_clk or negedge reset_n) begin
                if (!reset_n) begin
                    pending <= 1'b0;
                    dlyMs <= 16'h0000;
                    alarm <= 1'b0;
                end else if (clkEn) begin
                    if (alarmTick) begin
                        if (want && (delayMs == 16'h0000 || (pending && dlyMs >= delayMs))) begin
                            alarm <= !alarm;
                            pending <= 1'b0;
                            dlyMs <= 16'h0000;
                        end else begin
                            pending <= want;
                            if (!want) begin
                                dlyMs <= 16'h0000;
                            end
                        end
                    end else if (msTick && pending && dlyMs < delayMs) begin
                        dlyMs <= dlyMs + 16'h0001;
                    end
                end
            end

            assign alarmFlags[ch][a] = alarm;
        end

        assign processValue[ch] = pv;
        assign input_fault_flag[ch] = fault;
        assign breakDetected[ch] = brkOut;
        assign rateValue[ch] = rate;
    end
endmodule
`default_nettype wire

// File: bench/ifa_check_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ifa_check_sva (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire ifa_pkg::ifa_range_t [3:0] rangeSel,
    input wire logic [3:0][15:0] sampleValue,
    input wire logic convTick,
    input wire logic [3:0][15:0] processValue,
    input wire logic [3:0] input_fault_flag,
    input wire logic [3:0] breakDetected,
    input wire logic [3:0][16:0] rateValue,
    input wire logic [3:0][5:0] alarmFlags
);
    import ifa_pkg::*;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    sequence fresh_s;
        $past(convTick);
    endsequence
    sequence brk0_s;
        fresh_s ##0 breakDetected[0];
    endsequence
    tick_pulse_a: assert property (convTick && clkEn |=> !convTick)
        else $error("tick too wide");
    pv_hold_a: assert property (!$past(convTick) |-> $stable(processValue))
        else $error("value moved off tick");
    rate_hold_a: assert property (!$past(convTick, 2) |-> $stable(rateValue))
        else $error("rate moved off tick");
    alarm_hold_a: assert property (!$past(convTick, 3) |-> $stable(alarmFlags))
        else $error("alarm moved off tick");
    live_clamp_a: assert property (brk0_s ##0 $past(rangeSel[0]) == RNG_LIVE0
        |-> processValue[0] == PV_LO_15) else $error("live zero clamp");
    bip_clamp_a: assert property (brk0_s ##0 $past(rangeSel[0]) == RNG_BIPOLAR
        |-> processValue[0] == PV_MID) else $error("bipolar clamp");
    brk_fault_a: assert property (brk0_s ##0 $past(rangeSel[0]) inside {RNG_PT4,
        RNG_TEMP, RNG_MV100, RNG_LIVE0, RNG_UNI} |-> input_fault_flag[0])
        else $error("break without fault");
    // Bipolar band is narrower than the unipolar one, so both edges are checked
    bip_band_a: assert property (fresh_s ##0 !breakDetected[0]
        ##0 $past(rangeSel[0]) == RNG_BIPOLAR |-> input_fault_flag[0] ==
        ($signed($past(sampleValue[0])) > PV_HI_1075 ||
        $signed($past(sampleValue[0])) < PV_LO_75)) else $error("bipolar band");
endmodule
bind ifa_check ifa_check_sva u_sva (.core_clk(core_clk), .reset_n(reset_n), .clkEn(clkEn),
    .rangeSel(rangeSel), .sampleValue(sampleValue), .convTick(convTick),
    .processValue(processValue), .input_fault_flag(input_fault_flag),
    .breakDetected(breakDetected), .rateValue(rateValue), .alarmFlags(alarmFlags));
`default_nettype wire

// File: bench/ifa_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
module ifa_sensor_model (
    input wire logic core_clk,
    input wire logic [3:0][15:0] level,
    input wire logic [3:0] cut,
    output var logic [3:0][15:0] sampleValue,
    output var logic [3:0] wireBreak
);
    logic [15:0] drift = 16'h0000;
    // A cut lead floats, so the converted value wanders rather than holding
    always @(posedge core_clk) begin
        drift <= drift + 16'h3A5B;
    end
    always_comb begin
        for (int c = 0; c < 4; c++) begin
            sampleValue[c] = cut[c] ? drift : level[c];
        end
    end
    assign wireBreak = cut;
endmodule
`default_nettype wire

// File: bench/test_ifa_check.sv
`timescale 1ns/1ps
`default_nettype none
module test_ifa_check;
    import ifa_pkg::*;
    localparam int MS = 20;
    localparam logic signed [15:0] ONE = 16'sh0001;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic clkEn = 1'b1;
    logic [1:0] resSel = 2'h2;
    ifa_range_t [3:0] rangeSel = '{4{RNG_TEMP}};
    logic [3:0] clampHigh = 4'h0;
    logic [3:0] cut = 4'h0;
    logic [3:0][15:0] level = {4{PV_MID}};
    logic [3:0][5:0][15:0] alarmLimit = '0;
    logic [3:0][5:0][15:0] alarmHyst = '0;
    logic [3:0][5:0] alarmDelaySec = '0;
    logic [3:0][4:0] rateIntervalSec = '0;
    logic [3:0][15:0] sampleValue;
    logic [3:0] wireBreak;
    logic convTick;
    logic [3:0][15:0] processValue;
    logic [3:0] input_fault_flag;
    logic [3:0] breakDetected;
    logic [3:0][16:0] rateValue;
    logic [3:0][5:0] alarmFlags;
    int mismatches = 0;
    int checks_done = 0;
    int cyc = 0;
    int tickAt = 0;
    logic [5:0] msTab [3] = '{CONV_HIGH_MS, CONV_MED_MS, CONV_LOW_MS};
    ifa_range_t rngTab [12] = '{RNG_PT4, RNG_TEMP, RNG_MV100, RNG_LIVE0, RNG_UNI, RNG_UNI,
        RNG_MA020, RNG_MA020, RNG_BIPOLAR, RNG_BIPOLAR, RNG_BIPOLAR, RNG_TEMP};
    logic signed [15:0] valTab [12] = '{PV_HI_115 + ONE, PV_HI_115, PV_LO_15 - ONE, PV_LO_15,
        PV_LO_15 - ONE, PV_HI_115 + ONE, PV_LO_15 - ONE, PV_HI_115 + ONE, PV_HI_1075 + ONE,
        PV_LO_75, PV_LO_75 - ONE, PV_LO_15};
    logic [15:0] alVal [9] = '{16'h1388, 16'h1F41, 16'h1F0E, 16'h1EDC, 16'h07CF, 16'h03E7,
        16'h044B, 16'h044C, 16'h2329};
    logic [5:0] alExp [9] = '{6'h00, 6'h12, 6'h02, 6'h00, 6'h28, 6'h2C, 6'h0C, 6'h08, 6'h13};

    ifa_sensor_model sensors (.core_clk(core_clk), .level(level), .cut(cut),
        .sampleValue(sampleValue), .wireBreak(wireBreak));
    ifa_check #(.MS_CYC(MS)) DUT (.core_clk(core_clk), .reset_n(reset_n), .clkEn(clkEn),
        .resSel(resSel), .rangeSel(rangeSel), .clampHigh(clampHigh), .wireBreak(wireBreak),
        .sampleValue(sampleValue), .alarmLimit(alarmLimit), .alarmHyst(alarmHyst),
        .alarmDelaySec(alarmDelaySec), .rateIntervalSec(rateIntervalSec),
        .convTick(convTick), .processValue(processValue), .input_fault_flag(input_fault_flag),
        .breakDetected(breakDetected), .rateValue(rateValue), .alarmFlags(alarmFlags));

    always #10 core_clk = ~core_clk;

    task automatic close_out();
        if (mismatches == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            mismatches = mismatches + 1;
            close_out();
        end
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Returns once the alarm stage of this period has landed, three edges after the tick
    task automatic conv();
        int n;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (convTick !== 1'b1 && n < 1300);
        tickAt = cyc;
        if (n >= 1300) chk("convTick", 16'h0000, 16'h0001);
        repeat (4) @(negedge core_clk);
    endtask

    function automatic logic exp_fault(ifa_range_t r, logic signed [15:0] v);
        if (r == RNG_BIPOLAR) return v > PV_HI_1075 || v < PV_LO_75;
        if (r == RNG_MA020) return v > PV_HI_115;
        return v > PV_HI_115 || v < PV_LO_15;
    endfunction

    function automatic logic [15:0] exp_clamp(ifa_range_t r, logic hi);
        case (r)
            RNG_LIVE0: return PV_LO_15;
            RNG_UNI, RNG_MA020: return PV_ZERO;
            RNG_BIPOLAR: return PV_MID;
            default: return hi ? PV_HI_115 : PV_LO_15;
        endcase
    endfunction

    // Slow channels get the full second that the millivolt range is allowed
    task automatic brk_group(input ifa_range_t [3:0] r, input logic [3:0] hi,
        input logic [3:0] slow);
        @(posedge core_clk);
        rangeSel <= r;
        clampHigh <= hi;
        // Mid-scale keeps every range in band once the leads rejoin
        level <= {4{PV_MID}};
        cut <= 4'hF;
        for (int p = 0; p < 2; p++) begin
            repeat (10000) @(posedge core_clk);
            conv();
            for (int c = 0; c < 4; c++) begin
                if (slow[c] == p[0]) begin
                    chk("break", breakDetected[c], 16'h0001);
                    chk("brkfault", input_fault_flag[c],
                        16'(r[c] != RNG_MA020 && r[c] != RNG_BIPOLAR));
                    chk("clamp", processValue[c], exp_clamp(r[c], hi[c]));
                end
            end
        end
        @(posedge core_clk);
        cut <= 4'h0;
        conv();
        chk("rejoin", {breakDetected, input_fault_flag}, 16'h0000);
    endtask

    initial begin
        int t;
        logic [15:0] prev;
        repeat (4) @(posedge core_clk);
        reset_n <= 1'b1;
        for (int r = 0; r < 3; r++) begin
            @(posedge core_clk);
            resSel <= 2'(r);
            conv();
            conv();
            t = tickAt;
            conv();
            t = tickAt - t;
            chk("period", t[15:0], {10'h000, msTab[r]} * 16'(MS));
        end
        // A frozen stretch must push the next tick out by exactly its length
        conv();
        t = tickAt;
        @(posedge core_clk);
        clkEn <= 1'b0;
        repeat (300) @(posedge core_clk);
        clkEn <= 1'b1;
        conv();
        chk("freeze", 16'(tickAt - t), 16'h0190);
        for (int i = 0; i < 12; i++) begin
            @(posedge core_clk);
            rangeSel[0] <= rngTab[i];
            level[0] <= valTab[i];
            conv();
            chk("fault", input_fault_flag[0], exp_fault(rngTab[i], valTab[i]));
            chk("value", processValue[0], valTab[i]);
        end
        brk_group('{RNG_UNI, RNG_TEMP, RNG_MV100, RNG_LIVE0}, 4'h4, 4'h2);
        brk_group('{RNG_MV100, RNG_TEMP, RNG_MA020, RNG_BIPOLAR}, 4'h8, 4'h8);
        @(posedge core_clk);
        rangeSel[0] <= RNG_TEMP;
        alarmLimit[0] <= {16'hFE0C, 16'h01F4, 16'h07D0, 16'h03E8, 16'h1F40, 16'h2328};
        alarmHyst[0] <= {16'h0032, 16'h0032, {4{16'h0064}}};
        prev = PV_MID;
        for (int i = 0; i < 9; i++) begin
            @(posedge core_clk);
            level[0] <= alVal[i];
            conv();
            chk("alarms", alarmFlags[0], alExp[i]);
            chk("rate", rateValue[0][15:0], alVal[i] - prev);
            prev = alVal[i];
        end
        @(posedge core_clk);
        alarmDelaySec[0] <= 6'h01;
        level[0] <= 16'h1388;
        // Long interval on channel 1: the step must not show before it elapses
        rateIntervalSec[1] <= 5'h1F;
        level[1] <= 16'h1770;
        conv();
        chk("offdelay", alarmFlags[0], 6'h13);
        chk("rateint", rateValue[1][15:0], 16'h0000);
        chk("value", processValue[1], 16'h1770);
        repeat (18000) @(posedge core_clk);
        conv();
        chk("offdelay", alarmFlags[0], 6'h13);
        repeat (2200) @(posedge core_clk);
        conv();
        chk("offdelay", alarmFlags[0], 6'h00);
        chk("rateint", rateValue[1][15:0], 16'h0000);
        close_out();
    end
endmodule
`default_nettype wire
